// ### hw/incdec_bcd_consts.vh
// constants for the increment/decrement, decimal adjust and power-down unit
// assumes inclusion by the design file under hw/ and by the checker and bench under verification/
`ifndef INCDEC_BCD_CONSTS_VH
`define INCDEC_BCD_CONSTS_VH

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define OFS_CMD        12'h000
`define OFS_STATUS     12'h004
`define OFS_ACC        12'h008
`define OFS_MEMADDR    12'h00C
`define OFS_MEMDATA    12'h010
`define OFS_WDT        12'h014

// ----------------------------------------
// command codes (cmd register bits 2:0)
// ----------------------------------------
`define OP_NONE        3'h0
`define OP_DAA         3'h1
`define OP_DEC_MEM     3'h2
`define OP_DEC_ACC     3'h3
`define OP_INC_MEM     3'h4
`define OP_INC_ACC     3'h5
`define OP_HALT        3'h6
`define OP_WAKE        3'h7

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define ST_CARRY       0
`define ST_AUX         1
`define ST_ZERO        2
`define ST_PDF         3
`define ST_TO          4
`define ST_HALTED      5

// ----------------------------------------
// bcd correction, reset, memory depth and watchdog prescaler values
// ----------------------------------------
`define BCD_LIMIT      4'h9
`define BCD_FIX_LO     8'h06
`define BCD_FIX_HI     8'h60
`define RST_STATUS     8'h00
`define MEM_DEPTH      256
`define WDT_PRESC_MAX  8'hFF

`endif

// ### hw/incdec_bcd_unit.v
// eight-bit execution unit: decimal adjust, inc/dec, power-down
// assumes an apb master on clk; inputs synchronous to clk
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "incdec_bcd_consts.vh"

module incdec_bcd_unit
(
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         sysClkEn,
  output reg         watchdogTimeout,
  output reg         halted
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0] accumulator;
  reg  [7:0] memAddr;
  reg  [7:0] dataMem [0:`MEM_DEPTH-1];
  reg        carryFlag;
  reg        auxCarryFlag;
  reg        zeroFlag;
  reg        powerDownFlag;
  reg        watchdogTimeoutFlag;
  reg  [7:0] wdtPrescaler;
  reg [15:0] wdtCount;
  reg [15:0] wdtLimit;

  wire [7:0] memVal = dataMem[memAddr];
  wire       access = psel & penable;
  wire       wr     = access & pwrite;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [8:0] bcdAdjust;
    input [7:0] a;
    input       c;
    input       ac;
    reg   [7:0] fix;
    reg   [8:0] sum;
    begin
      fix = 8'h00;
      if ((a[3:0] > `BCD_LIMIT) || ac)
        fix = fix | `BCD_FIX_LO;
      // low fix may carry into the high nibble; check after it lands
      sum = {1'b0, a} + {1'b0, fix};
      if ((sum[7:4] > `BCD_LIMIT) || c || sum[8])
        sum = sum + {1'b0, `BCD_FIX_HI};
      bcdAdjust = sum;
    end
  endfunction

  function [7:0] step;
    input [7:0] v;
    input       up;
    begin
      step = up ? v + 8'h01 : v - 8'h01;
    end
  endfunction

  function isZero;
    input [7:0] v;
    begin
      isZero = (v == 8'h00);
    end
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire       cmdWrite = wr && (paddr == `OFS_CMD);
  wire [2:0] op       = pwdata[2:0];
  wire       known    = (paddr == `OFS_CMD) || (paddr == `OFS_STATUS) ||
                        (paddr == `OFS_ACC) || (paddr == `OFS_MEMADDR) ||
                        (paddr == `OFS_MEMDATA) || (paddr == `OFS_WDT);
  wire [8:0] daaRes   = bcdAdjust(accumulator, carryFlag, auxCarryFlag);
  wire [7:0] incVal   = step(memVal, 1'b1);
  wire [7:0] decVal   = step(memVal, 1'b0);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unused upper bits read zero
  reg [31:0] next_prdata;
  always @*
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_STATUS:  next_prdata = {26'h0, halted, watchdogTimeoutFlag, powerDownFlag,
                                   zeroFlag, auxCarryFlag, carryFlag};
      `OFS_ACC:     next_prdata = {24'h0, accumulator};
      `OFS_MEMADDR: next_prdata = {24'h0, memAddr};
      `OFS_MEMDATA: next_prdata = {24'h0, memVal};
      `OFS_WDT:     next_prdata = {wdtLimit, wdtCount};
      default:      next_prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  // one wait state: ready is launched in the first access cycle
  // and stands in the second, where the transfer commits
  wire firstAccess = access & ~pready;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= firstAccess;
      prdata  <= (firstAccess & ~pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= firstAccess & ~known;
    end
  end

  wire commit  = wr & pready;
  wire wakeCmd = commit && halted && cmdWrite && (op == `OP_WAKE);
  wire wdtTick = (wdtPrescaler == `WDT_PRESC_MAX);

  // ----------------------------------------
  // data memory; no port writes it while halted
  // ----------------------------------------
  // not reset: software initialises any location it reads back
  // one write source per cycle; the data port and commands never collide
  reg memPortWr;
  reg doDaa;
  reg doDecMem;
  reg doIncMem;
  always @*
  begin
    memPortWr = 1'b0;
    doDaa     = 1'b0;
    doDecMem  = 1'b0;
    doIncMem  = 1'b0;
    if (commit && !halted)
    begin
      if (paddr == `OFS_MEMDATA)
        memPortWr = 1'b1;
      else if (cmdWrite)
      begin
        case (op)
          `OP_DAA:     doDaa    = 1'b1;
          `OP_DEC_MEM: doDecMem = 1'b1;
          `OP_INC_MEM: doIncMem = 1'b1;
          default:
          begin
          end
        endcase
      end
    end
  end

  always @(posedge clk)
  begin
    if (memPortWr)
      dataMem[memAddr] <= pwdata[7:0];
    else if (doDaa)
      dataMem[memAddr] <= daaRes[7:0];
    else if (doDecMem)
      dataMem[memAddr] <= decVal;
    else if (doIncMem)
      dataMem[memAddr] <= incVal;
  end

  // ----------------------------------------
  // registers, flags, watchdog
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accumulator         <= 8'h00;
      memAddr             <= 8'h00;
      carryFlag           <= 1'b0;
      auxCarryFlag        <= 1'b0;
      zeroFlag            <= 1'b0;
      powerDownFlag       <= 1'b0;
      watchdogTimeoutFlag <= 1'b0;
      wdtPrescaler        <= 8'h00;
      wdtCount            <= 16'h0000;
      wdtLimit            <= 16'hFFFF;
      halted              <= 1'b0;
      sysClkEn            <= 1'b1;
      watchdogTimeout     <= 1'b0;
    end
    else
    begin
      // watchdog keeps running while halted; its timeout wakes the core
      // limitation: a limit below the running count fires only after wrap
      // the halt's clear of the timeout flag outranks a tick in that cycle
      if (halted && watchdogTimeoutFlag)
      begin
        halted   <= 1'b0;
        sysClkEn <= 1'b1;
      end
      if (wdtTick)
      begin
        wdtPrescaler <= 8'h00;
        if (wdtCount == wdtLimit)
        begin
          wdtCount            <= 16'h0000;
          watchdogTimeoutFlag <= 1'b1;
        end
        else
          wdtCount <= wdtCount + 16'h0001;
      end
      else
        wdtPrescaler <= wdtPrescaler + 8'h01;
      watchdogTimeout <= watchdogTimeoutFlag;

      if (wakeCmd)
      begin
        halted   <= 1'b0;
        sysClkEn <= 1'b1;
      end
      else if (commit && !halted)
      begin
        case (paddr)
          `OFS_ACC:     accumulator <= pwdata[7:0];
          `OFS_MEMADDR: memAddr     <= pwdata[7:0];
          `OFS_WDT:     wdtLimit    <= pwdata[31:16];
          `OFS_STATUS:
          begin
            carryFlag    <= pwdata[`ST_CARRY];
            auxCarryFlag <= pwdata[`ST_AUX];
            zeroFlag     <= pwdata[`ST_ZERO];
          end
          `OFS_CMD:
          begin
            case (op)
              `OP_DAA:
                carryFlag <= carryFlag | daaRes[8];
              `OP_DEC_MEM:
                zeroFlag <= isZero(decVal);
              `OP_DEC_ACC:
              begin
                accumulator <= decVal;
                zeroFlag    <= isZero(decVal);
              end
              `OP_INC_MEM:
                zeroFlag <= isZero(incVal);
              `OP_INC_ACC:
              begin
                accumulator <= incVal;
                zeroFlag    <= isZero(incVal);
              end
              `OP_HALT:
              begin
                halted              <= 1'b1;
                sysClkEn            <= 1'b0;
                wdtPrescaler        <= 8'h00;
                wdtCount            <= 16'h0000;
                powerDownFlag       <= 1'b1;
                watchdogTimeoutFlag <= 1'b0;
              end
              default:
              begin
              end
            endcase
          end
          default:
          begin
          end
        endcase
      end
    end
  end

endmodule // incdec_bcd_unit

`default_nettype wire

// ### verification/incdec_bcd_checker.sv
// checker: apb timing and power-down relations at the unit's ports
// assumes binding onto incdec_bcd_unit, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "incdec_bcd_consts.vh"
module incdec_bcd_checker
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sysClkEn,
  input wire logic        watchdogTimeout,
  input wire logic        halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic halt = psel && penable && pready && pwrite && paddr == `OFS_CMD
                    && pwdata[2:0] == `OP_HALT && !halted;
  ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  map_ok_a: assert property (pready |-> pslverr == (paddr > `OFS_WDT || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  rd_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray prdata");
  halt_enter_a: assert property (halt |=> halted && !sysClkEn)
    else $error("no halt");
  clk_gate_a: assert property (halted |-> !sysClkEn) else $error("clock on");
  to_clear_a: assert property (halt |=> ##1 !watchdogTimeout)
    else $error("timeout kept");
  cover property (halt);
  cover property (pslverr);
  cover property ($fell(halted));
endmodule // incdec_bcd_checker
bind incdec_bcd_unit incdec_bcd_checker chk_u (.*);
`default_nettype wire

// ### verification/mcu_incdec_bcd_halt_ops_test.sv
// bench: apb sequences over inc/dec, decimal adjust and power-down
// assumes incdec_bcd_unit with its header; 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "incdec_bcd_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mcu_incdec_bcd_halt_ops_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rv;
  logic [7:0]  v;
  logic        re;
  wire  [31:0] prdata;
  wire         pready, pslverr, sysClkEn, watchdogTimeout, halted;
  int          n_fail = 0;
  int          compares = 0;
  int          k;
  logic [7:0]  vals [3] = '{8'h00, 8'hFF, 8'hFE};
  // acc, {aux,carry}, expected result, expected carry
  logic [31:0] daa [6] = '{32'h15001500, 32'h1A002000, 32'hA5000501,
                           32'h9A000001, 32'h12021800, 32'h12017201};
  always #12.5 clk = ~clk;
  incdec_bcd_unit dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysClkEn(sysClkEn), .watchdogTimeout(watchdogTimeout), .halted(halted));
  task close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task apb(input logic w, logic [11:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    n_fail += (i == 20);
    if (i == 20)
      close_out();
    @(posedge clk);
  endtask
  task run(input logic [2:0] op, logic [11:0] a, logic [7:0] e, logic [2:0] f);
    apb(1'b1, `OFS_CMD, {29'h0, op});
    apb(1'b0, a, 32'h0);
    `CHK("result", e, rv[7:0])
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("flags", f, rv[2:0])
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("reset outputs", 3'h4, {sysClkEn, halted, watchdogTimeout})
    // carry and aux preset so a stray flag write shows
    foreach (vals[j])
    begin
      v = vals[j];
      apb(1'b1, `OFS_STATUS, 32'h3);
      apb(1'b1, `OFS_MEMDATA, {24'h0, v});
      run(`OP_INC_MEM, `OFS_MEMDATA, v + 8'h1, {v == 8'hFF, 2'h3});
      run(`OP_INC_ACC, `OFS_ACC, v + 8'h2, {v == 8'hFE, 2'h3});
      run(`OP_DEC_ACC, `OFS_ACC, v, {v == 8'h0, 2'h3});
      apb(1'b0, `OFS_MEMDATA, 32'h0);
      `CHK("mem kept", v + 8'h1, rv[7:0])
      run(`OP_DEC_MEM, `OFS_MEMDATA, v, {v == 8'h0, 2'h3});
    end
    $display("test incdec done");
    foreach (daa[j])
    begin
      apb(1'b1, `OFS_STATUS, {29'h0, 1'b1, daa[j][17:16]});
      apb(1'b1, `OFS_ACC, {24'h0, daa[j][31:24]});
      run(`OP_DAA, `OFS_MEMDATA, daa[j][15:8], {1'b1, daa[j][17], daa[j][0]});
    end
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    `CHK("slverr", 1'b1, re)
    apb(1'b0, `OFS_ACC, 32'h0);
    `CHK("no slverr", 1'b0, re)
    $display("test decimal done");
    apb(1'b1, `OFS_WDT, 32'h00020000);
    for (k = 0; k < 2000 && watchdogTimeout !== 1'b1; k++)
      @(posedge clk);
    `CHK("timeout", 1'b1, watchdogTimeout)
    if (k == 2000)
      close_out();
    apb(1'b1, `OFS_CMD, {29'h0, `OP_HALT});
    `CHK("clock", 1'b0, sysClkEn)
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("halt flags", 3'h5, rv[5:3])
    `CHK("timeout", 1'b0, watchdogTimeout)
    apb(1'b0, `OFS_WDT, 32'h0);
    `CHK("wdt", 32'h00020000, rv)
    // writes while halted must be dropped
    apb(1'b1, `OFS_ACC, 32'h5A);
    apb(1'b0, `OFS_ACC, 32'h0);
    `CHK("acc kept", 8'h12, rv[7:0])
    apb(1'b1, `OFS_MEMDATA, 32'hA5);
    apb(1'b0, `OFS_MEMDATA, 32'h0);
    `CHK("mem halted", 8'h72, rv[7:0])
    apb(1'b1, `OFS_CMD, {29'h0, `OP_WAKE});
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("awake", 2'h1, {halted, sysClkEn})
    $display("test powerdown done");
    close_out();
  end
endmodule // mcu_incdec_bcd_halt_ops_test
`default_nettype wire
